//--- common/sea_line_if.sv
// conditioned bus events passed from the pin front end to the protocol core
interface sea_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  logic wp;
  logic [2:0] cs;
  modport rx (output scl_rise, output scl_fall, output start, output stop, output sda, output wp, output cs);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda, input wp, input cs);
endinterface

//--- common/sea_pkg.sv
// constants, states and timing for the serial eeprom access block
// Behaviour
// - byte write: address, word address, one data byte acked; stop starts programming
// - while programming, no request is acknowledged, not even the slave address
// - 256 bytes, 16 pages of 16; upper nibble page, lower nibble byte
// - up to 16 data bytes are programmed in one write cycle
// - only the in-page address increments; extra bytes wrap and overwrite in the page
// - a page write starts programming right at the closing stop
// - write protect high blocks programming of the whole array
// - write protect low or open leaves writes allowed
// - counter points past the last byte accessed, wrapping from last to first
// - read address byte is acked on the 9th clock, then the counter's byte shifts out
// - selective read: dummy write loads the counter, then repeated start and read
// - bytes keep coming from incrementing addresses while the master acks
// - sequential read wraps from the last location to the first
// - slave address is 1010, three chip-select bits matched to pins, then read/write
// - data sampled on clock rise, driven data changes on clock fall
// - stop after a read returns to standby without programming
package sea_pkg;
  // ===========================================
  // addressing
  localparam logic [3:0] DEV_PATTERN = 4'ha;
  localparam int ADDR_W = 8;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 256;
  localparam int PIN_W = 6;
  localparam logic [5:0] PIN_RESET = 6'h03;
  // ===========================================
  // bit counter marks within one nine-clock byte slot
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  // ===========================================
  // internal write cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WR_TIME_NS = 5000000;
  localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;
  localparam int WR_CNT_W = 20;
  // ===========================================
  // transfer phases
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_WORD = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_SKIP = 6'h20
  } sea_state_t;
endpackage

//--- core/sea_eeprom.sv
// serial eeprom slave: protocol engine, page buffer, array and write cycle timer
module sea_eeprom
  import sea_pkg::*;
#(
  parameter int unsigned P_WR_CYCLES = sea_pkg::WR_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_wp,
  input wire logic i_chip_select_bit0,
  input wire logic i_chip_select_bit1,
  input wire logic i_chip_select_bit2,
  output logic o_busy
);
  import sea_pkg::*;

  sea_line_if line ();
  sea_state_t state;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [ADDR_W-1:0] addr;
  logic rw;
  logic pull;
  logic busy;
  logic [WR_CNT_W-1:0] tmr;
  logic [PAGE_BYTES-1:0] valid;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [MEM_BYTES];
  logic match;
  logic ack_now;
  logic commit;
  logic [PAGE_W-1:0] page_off;

  sea_line_rx u_rx (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_scl(i_scl),
    .i_sda(i_sda_i),
    .i_wp(i_wp),
    .i_cs({i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0}),
    .o_line(line)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  // ===========================================
  // decode of the completed byte
  assign match = (shift[7:4] == DEV_PATTERN) && (shift[3:1] == line.cs);
  assign ack_now = (state == ST_ADDR) ? (match && !busy) : (state == ST_WORD || state == ST_WDATA);
  assign commit = line.stop && state == ST_WDATA && valid != '0 && !line.wp;
  assign page_off = addr[PAGE_W-1:0];

  // ===========================================
  // bit engine: samples on clock rise, decides phase on clock fall, except a read nack, which moves to ST_SKIP on the rise
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      rw <= 1'b0;
    end else if (line.start) begin
      state <= ST_ADDR;
      cnt <= 4'h0;
    end else if (line.stop) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
    end else if (line.scl_rise && state != ST_IDLE && state != ST_SKIP) begin
      cnt <= cnt + 4'h1;
      if (cnt < BIT_ACK) begin
        shift <= {shift[6:0], line.sda};
      end
      if (state == ST_RDATA && cnt == BIT_ACK && line.sda) begin
        state <= ST_SKIP;
      end
    end else if (line.scl_fall && cnt == BIT_ACK) begin
      if (state == ST_ADDR) begin
        rw <= shift[0];
        if (!ack_now) begin
          state <= ST_SKIP;
        end
      end
    end else if (line.scl_fall && cnt == BIT_DONE) begin
      cnt <= 4'h0;
      if (state == ST_ADDR) begin
        state <= rw ? ST_RDATA : ST_WORD;
      end else if (state == ST_WORD) begin
        state <= ST_WDATA;
      end
    end
  end

  // ===========================================
  // open-drain driver; changes only on clock fall, released on start and stop
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pull <= 1'b0;
      tx <= 8'h00;
    end else if (line.start || line.stop) begin
      pull <= 1'b0;
    end else if (line.scl_fall) begin
      if (cnt == BIT_ACK) begin
        pull <= (state == ST_RDATA) ? 1'b0 : ack_now;
      end else if (cnt == BIT_DONE) begin
        // read data: load the byte under the counter and put out its msb
        if (state == ST_RDATA || (state == ST_ADDR && rw)) begin
          tx <= mem[addr];
          pull <= ~mem[addr][7];
        end else begin
          pull <= 1'b0;
        end
      end else if (state == ST_RDATA && cnt != 4'h0) begin
        tx <= {tx[6:0], 1'b0};
        pull <= ~tx[6];
      end
    end
  end

  // ===========================================
  // address counter: word load, in-page step on writes, full wrap on reads
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr <= 8'h00;
    end else if (line.scl_fall && cnt == BIT_ACK && state == ST_WORD) begin
      addr <= shift;
    end else if (line.scl_fall && cnt == BIT_ACK && state == ST_WDATA) begin
      addr <= {addr[ADDR_W-1:PAGE_W], page_off + 4'h1};
    end else if (line.scl_rise && cnt == BIT_ACK && state == ST_RDATA) begin
      addr <= addr + 8'h01;
    end
  end

  // ===========================================
  // page buffer occupancy; a repeated start abandons buffered data
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid <= '0;
    end else if (line.start || line.stop) begin
      valid <= '0;
    end else if (line.scl_fall && cnt == BIT_ACK && state == ST_WDATA) begin
      valid[page_off] <= 1'b1;
    end
  end

  // array and page buffer hold no reset; contents are undefined until written
  always_ff @(posedge i_sys_clk) begin
    if (line.scl_fall && cnt == BIT_ACK && state == ST_WDATA) begin
      pbuf[page_off] <= shift;
    end
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (valid[i]) begin
          mem[{addr[ADDR_W-1:PAGE_W], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // ===========================================
  // write cycle timer; a protected write never goes busy
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy <= 1'b0;
      tmr <= '0;
    end else if (commit) begin
      busy <= 1'b1;
      tmr <= WR_CNT_W'(P_WR_CYCLES - 1);
    end else if (busy) begin
      if (tmr == '0) begin
        busy <= 1'b0;
      end else begin
        tmr <= tmr - 1'b1;
      end
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = pull;
  assign o_busy = busy;

  // ===========================================
  // checks
  property p_busy_nack;
    (busy && state == ST_ADDR && line.scl_fall && cnt == BIT_ACK) |=> !pull && state == ST_SKIP;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

  property p_addr_ack;
    (!busy && state == ST_ADDR && match && line.scl_fall && cnt == BIT_ACK && !line.start) |=> pull;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");

  property p_addr_mismatch;
    (state == ST_ADDR && !match && line.scl_fall && cnt == BIT_ACK) |=> !pull ##1 !pull;
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch) else $error("foreign address acked");

  property p_stop_starts_write;
    (line.stop && state == ST_WDATA && valid != '0 && !line.wp) |=> busy && tmr == WR_CNT_W'(P_WR_CYCLES - 1);
  endproperty
  a_stop_starts_write: assert property (p_stop_starts_write) else $error("stop did not start write");

  property p_protect_idle;
    (line.stop && line.wp && !busy) |=> !busy;
  endproperty
  a_protect_idle: assert property (p_protect_idle) else $error("protected write went busy");

  property p_read_stop_idle;
    (line.stop && !busy && state != ST_WDATA) |=> !busy && state == ST_IDLE;
  endproperty
  a_read_stop_idle: assert property (p_read_stop_idle) else $error("stop after read started write");

  property p_page_wrap;
    (state == ST_WDATA && line.scl_fall && cnt == BIT_ACK)
      |=> addr[7:4] == $past(addr[7:4]) && page_off == 4'($past(page_off) + 4'h1);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("write address left the page");

  property p_read_inc;
    (state == ST_RDATA && line.scl_rise && cnt == BIT_ACK && !line.start && !line.stop) |=> addr == 8'($past(addr) + 8'h01);
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read counter not stepped");

  property p_drive_on_fall;
    $changed(pull) |-> $past(line.scl_fall) || $past(line.start) || $past(line.stop);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("data changed off clock fall");

  property p_busy_min;
    $rose(busy) |-> busy [*4];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
endmodule

//--- core/sea_line_rx.sv
// pin synchronisers, glitch filter and start/stop/edge detection
module sea_line_rx
  import sea_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic [2:0] i_cs,
  sea_line_if.rx o_line
);
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] prev;

  // ===========================================
  // three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= PIN_RESET;
      sync2 <= PIN_RESET;
      sync3 <= PIN_RESET;
    end else begin
      sync1 <= {i_cs, i_wp, i_sda, i_scl};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a level only moves once stages two and three agree, rejecting single-cycle spikes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lvl <= PIN_RESET;
      prev <= PIN_RESET;
    end else begin
      lvl <= (sync3 & ~(sync2 ^ sync3)) | (lvl & (sync2 ^ sync3));
      prev <= lvl;
    end
  end

  // ===========================================
  // events: data moving while the clock stays high are start and stop
  assign o_line.scl_rise = lvl[0] & ~prev[0];
  assign o_line.scl_fall = ~lvl[0] & prev[0];
  assign o_line.start = lvl[0] & prev[0] & prev[1] & ~lvl[1];
  assign o_line.stop = lvl[0] & prev[0] & ~prev[1] & lvl[1];
  assign o_line.sda = lvl[1];
  assign o_line.wp = lvl[2];
  assign o_line.cs = lvl[5:3];

  property p_cond_needs_high_clock;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_line.start || o_line.stop) |-> lvl[0] && $past(lvl[0]) && !o_line.scl_rise;
  endproperty
  a_cond_needs_high_clock: assert property (p_cond_needs_high_clock) else $error("start or stop without high clock");
endmodule

//--- sim/sea_i2c_master.sv
// bus master model for the serial eeprom block: clock, start/stop and byte slots
module sea_i2c_master (
  input wire logic i_sys_clk,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull = 1'b0;
  initial o_scl = 1'b1;
  // ==========================================
  // wire level
  // open drain with pull-up: low whenever either party pulls
  assign o_sda = ~(pull | i_sda_oe);
  // ==========================================
  // timing helpers
  // all changes land one ns after the edge so no race with the device
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // data set mid-low, sampled mid-high; phases of 10 clocks beat the filter
  task automatic bit_slot(input logic drv, output logic smp);
    pull = ~drv;
    tick(5);
    o_scl = 1'b1;
    tick(5);
    smp = o_sda;
    tick(5);
    o_scl = 1'b0;
    tick(5);
  endtask
  // ==========================================
  // conditions
  // also serves as repeated start from a low clock
  task automatic start();
    pull = 1'b0;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    pull = 1'b1;
    tick(10);
    o_scl = 1'b0;
    tick(5);
  endtask
  task automatic stop();
    pull = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(10);
    pull = 1'b0;
    tick(10);
  endtask
  // ==========================================
  // byte slots, msb first
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, s);
    ack = (s === 1'b0);
  endtask
  // last byte of a read is left unacknowledged by the caller
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(~mack, s);
  endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the serial eeprom access block
module tb_top
  import sea_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WR_CYC = 400;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic scl, sda, sda_o, sda_oe, busy, scl_q, oe_q;
  logic [7:0] mem [256];
  logic known [256];
  logic [7:0] ctr;
  int miscompares = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  sea_i2c_master master (.i_sys_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  sea_eeprom #(.P_WR_CYCLES(WR_CYC)) uut (.i_sys_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda_i(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_wp(wp), .i_chip_select_bit0(cs[0]), .i_chip_select_bit1(cs[1]),
    .i_chip_select_bit2(cs[2]), .o_busy(busy));
  // ==========================================
  // expectation helpers
  function automatic logic [7:0] dev(input logic rw);
    return {DEV_PATTERN, cs, rw};
  endfunction
  // in-page step: only the low nibble moves
  function automatic logic [7:0] slot(input logic [7:0] a, input int k);
    return {a[7:4], 4'(a[3:0] + k)};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // transactions
  task automatic page_write(input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] d;
    master.start();
    master.wbyte(dev(1'b0), ack);
    chk("addr ack", 8'h01, {7'h0, ack});
    master.wbyte(a, ack);
    chk("word ack", 8'h01, {7'h0, ack});
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      master.wbyte(d, ack);
      chk("data ack", 8'h01, {7'h0, ack});
      if (wp !== 1'b1) begin
        mem[slot(a, k)] = d;
        known[slot(a, k)] = 1'b1;
      end
    end
    master.stop();
    master.tick(10);
    chk("busy after write", {7'h0, (wp !== 1'b1 && n > 0)}, {7'h0, busy});
    // a protected write still walks the counter through the page
    ctr = slot(a, n);
  endtask
  // probe until the address is acknowledged, bounded
  task automatic wait_ready(input logic exp_first);
    logic ack;
    for (int p = 0; p < 8; p++) begin
      master.start();
      master.wbyte(dev(1'b0), ack);
      master.stop();
      if (p == 0)
        chk("first poll ack", {7'h0, exp_first}, {7'h0, ack});
      if (ack === 1'b1)
        break;
    end
    // running out of polls is a hang of the write cycle
    chk("poll ready", 8'h01, {7'h0, ack});
  endtask
  task automatic read_seq(input logic sel, input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] d;
    if (sel) begin
      master.start();
      master.wbyte(dev(1'b0), ack);
      master.wbyte(a, ack);
      chk("dummy word ack", 8'h01, {7'h0, ack});
      ctr = a;
    end
    master.start();
    master.wbyte(dev(1'b1), ack);
    chk("read addr ack", 8'h01, {7'h0, ack});
    for (int k = 0; k < n; k++) begin
      master.rbyte(k < n - 1, d);
      if (known[ctr])
        chk("read data", mem[ctr], d);
      ctr = ctr + 8'h01;
    end
    master.stop();
    master.tick(10);
    chk("busy after read", 8'h00, {7'h0, busy});
  endtask
  // ==========================================
  // driven data may only move while the clock is low
  always @(posedge clk) begin
    if (resetn && scl_q === 1'b1 && scl === 1'b1 && sda_oe !== oe_q) begin
      $display("wrong value sda_oe during high clock expected %b seen %b", oe_q, sda_oe);
      miscompares++;
    end
    // open drain: the driven value itself is never anything but low
    if (sda_o !== 1'b0) begin
      $display("wrong value sda_o expected 0 seen %b", sda_o);
      miscompares++;
    end
    scl_q <= scl;
    oe_q <= sda_oe;
  end
  // watchdog sized well above the expected run of some 21k clocks
  initial begin
    repeat (80000) @(posedge clk);
    $display("wrong value watchdog expected done seen hang");
    miscompares++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    logic ack;
    logic [7:0] a;
    void'($urandom(32'h4484450f));
    foreach (known[i]) known[i] = 1'b0;
    cs = 3'($urandom);
    master.tick(3);
    resetn = 1'b1;
    master.tick(10);
    page_write({4'hf, 4'($urandom)}, 16);
    wait_ready(1'b0);
    page_write({4'h0, 4'($urandom)}, 18);
    wait_ready(1'b0);
    read_seq(1'b0, 8'h00, 3);
    read_seq(1'b1, 8'hfe, 4);
    for (int t = 0; t < 4; t++) begin
      a = 8'($urandom);
      page_write(a, 1);
      wait_ready(1'b0);
      read_seq(1'b1, a, 1);
    end
    // reset in the middle of a write cycle must drop busy and free the line
    page_write(8'h40, 1);
    resetn = 1'b0;
    master.tick(2);
    chk("busy in reset", 8'h00, {7'h0, busy});
    chk("oe in reset", 8'h00, {7'h0, sda_oe});
    resetn = 1'b1;
    master.tick(10);
    wait_ready(1'b1);
    wp = 1'b1;
    page_write(8'hf3, 2);
    wait_ready(1'b1);
    read_seq(1'b1, 8'hf3, 2);
    wp = 1'b0;
    master.start();
    master.wbyte({DEV_PATTERN, ~cs, 1'b1}, ack);
    chk("wrong select ack", 8'h00, {7'h0, ack});
    master.stop();
    master.start();
    master.wbyte({4'h5, cs, 1'b1}, ack);
    chk("wrong pattern ack", 8'h00, {7'h0, ack});
    master.stop();
    summarize();
  end
endmodule
